/* File: hw/tmc_pkg.sv */
package tmc_pkg;

   // Special function register addresses.
   localparam logic [7:0] ADDR_TCTRL = 8'h88;
   localparam logic [7:0] ADDR_TMODE = 8'h89;
   localparam logic [7:0] ADDR_FIRST_LOW = 8'h8a;
   localparam logic [7:0] ADDR_SECOND_LOW = 8'h8b;
   localparam logic [7:0] ADDR_FIRST_HIGH = 8'h8c;
   localparam logic [7:0] ADDR_SECOND_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_RATE_CTRL = 8'h8e;

   // Reset values.
   localparam logic [7:0] RST_TCTRL = 8'h00;
   localparam logic [7:0] RST_TMODE = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_RATE_CTRL = 8'h01;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // Bit positions in timer_control_flags.
   localparam int unsigned BIT_SECOND_OVF = 7;
   localparam int unsigned BIT_SECOND_RUN = 6;
   localparam int unsigned BIT_FIRST_OVF = 5;
   localparam int unsigned BIT_FIRST_RUN = 4;
   localparam int unsigned BIT_SECOND_IRQ_DET = 3;
   localparam int unsigned BIT_SECOND_IRQ_TYPE = 2;
   localparam int unsigned BIT_FIRST_IRQ_DET = 1;
   localparam int unsigned BIT_FIRST_IRQ_TYPE = 0;

   // Field positions in timer_mode_select.
   localparam int unsigned TMODE_SECOND_LSB = 4;
   localparam int unsigned TMODE_FIRST_LSB = 0;

   // Rate bits in clock_rate_control.
   localparam int unsigned BIT_FIRST_RATE = 3;
   localparam int unsigned BIT_SECOND_RATE = 4;

   // Mode numbers.
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;

   // Prescaler: last count of the 12-cycle period and of each 4-cycle quarter.
   localparam logic [3:0] PRESC_LAST = 4'hb;
   localparam logic [1:0] QUARTER_LAST = 2'h3;
   localparam logic [3:0] PRESC_RST = 4'h0;

   // Pin history reset values: interrupt pins idle high, count pins low.
   localparam logic [1:0] IRQ_PREV_RST = 2'h3;
   localparam logic [1:0] COUNT_PREV_RST = 2'h0;
   localparam logic [1:0] PULSE_RST = 2'h0;

   typedef struct packed {
      logic gate;
      logic count_sel;
      logic [1:0] mode;
   } tmc_timer_cfg_s;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } tmc_sfr_req_s;

   typedef struct packed {
      logic [7:0] tctrl;
      logic [7:0] tmode;
      logic [7:0] rate_ctrl;
      logic [7:0] first_low;
      logic [7:0] first_high;
      logic [7:0] second_low;
      logic [7:0] second_high;
      logic [3:0] presc;
      logic [1:0] count_prev;
      logic [1:0] irq_prev;
      logic [1:0] ovf_pulse;
      logic [7:0] rdata;
   } tmc_state_s;

   localparam tmc_state_s STATE_RST = '{
      tctrl: RST_TCTRL,
      tmode: RST_TMODE,
      rate_ctrl: RST_RATE_CTRL,
      first_low: RST_COUNT,
      first_high: RST_COUNT,
      second_low: RST_COUNT,
      second_high: RST_COUNT,
      presc: PRESC_RST,
      count_prev: COUNT_PREV_RST,
      irq_prev: IRQ_PREV_RST,
      ovf_pulse: PULSE_RST,
      rdata: RST_RDATA
   };

endpackage : tmc_pkg

/* File: hw/tmc_inc_gate.sv */
`timescale 1ns/100ps
`default_nettype none

// Decides whether one counter advances in this cycle.
module tmc_inc_gate (
   input wire logic i_run,
   input wire logic i_gate,
   input wire logic i_irq_level,
   input wire logic i_count_sel,
   input wire logic i_fast_rate,
   input wire logic i_tick4,
   input wire logic i_tick12,
   input wire logic i_count_fall,
   output logic o_inc
);

   logic source_event;

   always_comb begin
      if (i_count_sel) begin
         source_event = i_count_fall;
      end else begin
         source_event = i_fast_rate ? i_tick4 : i_tick12;
      end
   end

   assign o_inc = i_run & (~i_gate | i_irq_level) & source_event;

endmodule : tmc_inc_gate

`default_nettype wire

/* File: hw/tmc_timers.sv */
// Functional notes
// - Mode 0 counts 13 bits: low five bits of low byte plus high byte.
// - Mode 0 wrap from all ones sets overflow flag and one-cycle output pulse.
// - Counting proceeds only when gate is 0 or the interrupt pin is high.
// - Mode 1 counts all sixteen bits; flags, pulse and gating as mode 0.
// - Mode 2: low byte counts, high byte reloads it after all ones.
// - Source select picks prescaled core clock or external count pin.
// - Mode register: second timer fields in bits 7-4, first in 3-0.
// - Modes 0-2 on both timers; split mode 3 only on first timer.
// - Timers count only while run bit set, except the second while the first is split; run bits at 6 and 4.
// - Edge mode: falling pin edge sets flag; vectoring or software clears it.
// - Level mode: flag follows inverted pin; software writes ignored.
// - Type bit 1 selects edge, 0 level; bits 2 and 0.
// - Counter mode advances once per falling edge on the count pin.
// - Rate bit 1 gives every 4 clocks, 0 every 12; ignored as counter.
// - Split mode borrows second run and overflow bits; second timer holds in mode 3.
`timescale 1ns/100ps
`default_nettype none

module tmc_timers (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire tmc_pkg::tmc_sfr_req_s i_sfr,
   output logic [7:0] o_sfr_rdata,
   input wire logic i_first_ext_irq_pin_n,
   input wire logic i_second_ext_irq_pin_n,
   input wire logic i_first_count_pin,
   input wire logic i_second_count_pin,
   input wire logic i_vector_first_timer,
   input wire logic i_vector_second_timer,
   input wire logic i_vector_first_ext_irq,
   input wire logic i_vector_second_ext_irq,
   output logic o_first_overflow_pulse,
   output logic o_second_overflow_pulse
);

   tmc_pkg::tmc_state_s st;
   tmc_pkg::tmc_state_s next_st;

   tmc_pkg::tmc_timer_cfg_s cfg_first;
   tmc_pkg::tmc_timer_cfg_s cfg_second;
   logic tick4;
   logic tick12;
   logic [1:0] irq_level;
   logic [1:0] count_pin;
   logic [1:0] count_fall;
   logic [1:0] irq_fall;
   logic first_split;
   logic second_run;
   logic inc_first;
   logic inc_second;
   logic inc_split_high;
   logic sel_tctrl;
   logic sel_tmode;
   logic sel_first_low;
   logic sel_second_low;
   logic sel_first_high;
   logic sel_second_high;
   logic sel_rate_ctrl;

   // Returns {overflow, high, low} after one step of modes 0 to 2.
   function automatic logic [16:0] tmc_step(
      input logic [1:0] mode,
      input logic [7:0] low,
      input logic [7:0] high,
      input logic en
   );
      logic [16:0] res;
      logic [12:0] c13;
      logic [15:0] c16;
      res = {1'b0, high, low};
      c13 = {high, low[4:0]} + 13'h0001;
      c16 = {high, low} + 16'h0001;
      if (en) begin
         case (mode)
            tmc_pkg::MODE_13BIT: begin
               // Upper three low-byte bits are left untouched.
               res = {&{high, low[4:0]}, c13[12:5], low[7:5], c13[4:0]};
            end
            tmc_pkg::MODE_16BIT: begin
               res = {&{high, low}, c16};
            end
            tmc_pkg::MODE_RELOAD: begin
               if (&low) begin
                  res = {1'b1, high, high};
               end else begin
                  res = {1'b0, high, low + 8'h01};
               end
            end
            tmc_pkg::MODE_SPLIT: begin
               // The second timer holds its count while set to mode 3.
               res = {1'b0, high, low};
            end
            default: begin
               res = {1'b0, high, low};
            end
         endcase
      end
      return res;
   endfunction : tmc_step

   assign cfg_first = tmc_pkg::tmc_timer_cfg_s'(st.tmode[tmc_pkg::TMODE_FIRST_LSB +: 4]);
   assign cfg_second = tmc_pkg::tmc_timer_cfg_s'(st.tmode[tmc_pkg::TMODE_SECOND_LSB +: 4]);
   assign tick4 = (st.presc[1:0] == tmc_pkg::QUARTER_LAST);
   assign tick12 = (st.presc == tmc_pkg::PRESC_LAST);
   assign irq_level = {i_second_ext_irq_pin_n, i_first_ext_irq_pin_n};
   assign count_pin = {i_second_count_pin, i_first_count_pin};
   // A count pin pulse shorter than one clock can be missed, as pins are sampled once a clock.
   assign count_fall = st.count_prev & ~count_pin;
   assign irq_fall = st.irq_prev & ~irq_level;
   assign first_split = (cfg_first.mode == tmc_pkg::MODE_SPLIT);

   // One match line per register, shared by the write and the read decode.
   assign sel_tctrl = (i_sfr.addr == tmc_pkg::ADDR_TCTRL);
   assign sel_tmode = (i_sfr.addr == tmc_pkg::ADDR_TMODE);
   assign sel_first_low = (i_sfr.addr == tmc_pkg::ADDR_FIRST_LOW);
   assign sel_second_low = (i_sfr.addr == tmc_pkg::ADDR_SECOND_LOW);
   assign sel_first_high = (i_sfr.addr == tmc_pkg::ADDR_FIRST_HIGH);
   assign sel_second_high = (i_sfr.addr == tmc_pkg::ADDR_SECOND_HIGH);
   assign sel_rate_ctrl = (i_sfr.addr == tmc_pkg::ADDR_RATE_CTRL);

   // While the first timer is split, the second timer runs whenever its mode is not 3.
   assign second_run = (first_split | st.tctrl[tmc_pkg::BIT_SECOND_RUN])
      & (cfg_second.mode != tmc_pkg::MODE_SPLIT);

   tmc_inc_gate u_gate_first (
      .i_run(st.tctrl[tmc_pkg::BIT_FIRST_RUN]),
      .i_gate(cfg_first.gate),
      .i_irq_level(irq_level[0]),
      .i_count_sel(cfg_first.count_sel),
      .i_fast_rate(st.rate_ctrl[tmc_pkg::BIT_FIRST_RATE]),
      .i_tick4(tick4),
      .i_tick12(tick12),
      .i_count_fall(count_fall[0]),
      .o_inc(inc_first)
   );

   tmc_inc_gate u_gate_second (
      .i_run(second_run),
      .i_gate(cfg_second.gate),
      .i_irq_level(irq_level[1]),
      .i_count_sel(cfg_second.count_sel),
      .i_fast_rate(st.rate_ctrl[tmc_pkg::BIT_SECOND_RATE]),
      .i_tick4(tick4),
      .i_tick12(tick12),
      .i_count_fall(count_fall[1]),
      .o_inc(inc_second)
   );

   // The split high half only counts the prescaled clock, under the second run bit.
   tmc_inc_gate u_gate_split_high (
      .i_run(st.tctrl[tmc_pkg::BIT_SECOND_RUN] & first_split),
      .i_gate(1'b0),
      .i_irq_level(1'b1),
      .i_count_sel(1'b0),
      .i_fast_rate(st.rate_ctrl[tmc_pkg::BIT_FIRST_RATE]),
      .i_tick4(tick4),
      .i_tick12(tick12),
      .i_count_fall(1'b0),
      .o_inc(inc_split_high)
   );

   always_comb begin
      logic [16:0] step_first;
      logic [16:0] step_second;
      logic ovf_first;
      logic ovf_second_flag;
      logic ovf_second_timer;
      logic [7:0] tctrl_n;
      next_st = st;
      ovf_first = 1'b0;
      ovf_second_flag = 1'b0;
      tctrl_n = st.tctrl;
      step_first = tmc_step(cfg_first.mode, st.first_low, st.first_high, inc_first);
      step_second = tmc_step(cfg_second.mode, st.second_low, st.second_high, inc_second);
      ovf_second_timer = step_second[16];

      // The prescaler is shared, so timers set to the same rate tick on the same edges.
      next_st.presc = tick12 ? tmc_pkg::PRESC_RST : st.presc + 4'h1;
      next_st.count_prev = count_pin;
      next_st.irq_prev = irq_level;

      // In split mode the high half borrows the second timer's run bit and overflow flag.
      if (first_split) begin
         next_st.first_low = st.first_low + {7'h00, inc_first};
         next_st.first_high = st.first_high + {7'h00, inc_split_high};
         ovf_first = inc_first & (&st.first_low);
         ovf_second_flag = inc_split_high & (&st.first_high);
      end else begin
         next_st.first_low = step_first[7:0];
         next_st.first_high = step_first[15:8];
         ovf_first = step_first[16];
         ovf_second_flag = ovf_second_timer;
      end
      next_st.second_low = step_second[7:0];
      next_st.second_high = step_second[15:8];
      next_st.ovf_pulse = {ovf_second_flag, ovf_first};

      // Software writes to count bytes take priority over the increment.
      if (i_sfr.wr && sel_tmode) begin
         next_st.tmode = i_sfr.wdata;
      end
      if (i_sfr.wr && sel_first_low) begin
         next_st.first_low = i_sfr.wdata;
      end
      if (i_sfr.wr && sel_second_low) begin
         next_st.second_low = i_sfr.wdata;
      end
      if (i_sfr.wr && sel_first_high) begin
         next_st.first_high = i_sfr.wdata;
      end
      if (i_sfr.wr && sel_second_high) begin
         next_st.second_high = i_sfr.wdata;
      end
      if (i_sfr.wr && sel_rate_ctrl) begin
         next_st.rate_ctrl = i_sfr.wdata;
      end

      if (i_sfr.wr && sel_tctrl) begin
         tctrl_n = i_sfr.wdata;
      end
      // Vectoring to a timer's service routine clears its overflow flag.
      if (i_vector_first_timer) begin
         tctrl_n[tmc_pkg::BIT_FIRST_OVF] = 1'b0;
      end
      if (i_vector_second_timer) begin
         tctrl_n[tmc_pkg::BIT_SECOND_OVF] = 1'b0;
      end
      // Hardware set wins over any clear in the same cycle.
      if (ovf_first) begin
         tctrl_n[tmc_pkg::BIT_FIRST_OVF] = 1'b1;
      end
      if (ovf_second_flag) begin
         tctrl_n[tmc_pkg::BIT_SECOND_OVF] = 1'b1;
      end

      // The type bit acts from the cycle after it is written.
      if (st.tctrl[tmc_pkg::BIT_FIRST_IRQ_TYPE]) begin
         if (i_vector_first_ext_irq) begin
            tctrl_n[tmc_pkg::BIT_FIRST_IRQ_DET] = 1'b0;
         end
         if (irq_fall[0]) begin
            tctrl_n[tmc_pkg::BIT_FIRST_IRQ_DET] = 1'b1;
         end
      end else begin
         tctrl_n[tmc_pkg::BIT_FIRST_IRQ_DET] = ~irq_level[0];
      end
      if (st.tctrl[tmc_pkg::BIT_SECOND_IRQ_TYPE]) begin
         if (i_vector_second_ext_irq) begin
            tctrl_n[tmc_pkg::BIT_SECOND_IRQ_DET] = 1'b0;
         end
         if (irq_fall[1]) begin
            tctrl_n[tmc_pkg::BIT_SECOND_IRQ_DET] = 1'b1;
         end
      end else begin
         tctrl_n[tmc_pkg::BIT_SECOND_IRQ_DET] = ~irq_level[1];
      end
      next_st.tctrl = tctrl_n;

      if (i_sfr.rd) begin
         // Unmapped addresses read as zero.
         next_st.rdata = tmc_pkg::RST_RDATA;
         if (sel_tctrl) begin
            next_st.rdata = st.tctrl;
         end
         if (sel_tmode) begin
            next_st.rdata = st.tmode;
         end
         if (sel_first_low) begin
            next_st.rdata = st.first_low;
         end
         if (sel_second_low) begin
            next_st.rdata = st.second_low;
         end
         if (sel_first_high) begin
            next_st.rdata = st.first_high;
         end
         if (sel_second_high) begin
            next_st.rdata = st.second_high;
         end
         if (sel_rate_ctrl) begin
            next_st.rdata = st.rate_ctrl;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= tmc_pkg::STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign o_sfr_rdata = st.rdata;
   assign o_first_overflow_pulse = st.ovf_pulse[0];
   assign o_second_overflow_pulse = st.ovf_pulse[1];

endmodule : tmc_timers

`default_nettype wire

/* File: tb/tmc_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Core side of the register bus: strobes stay up until idle() drops them.
module tmc_core_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output tmc_pkg::tmc_sfr_req_s o_sfr,
   output logic [3:0] o_vec
);
   initial begin
      o_sfr = '0;
      o_vec = 4'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      o_sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(posedge i_clk) #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      o_sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge i_clk) #1;
      v = i_rdata;
   endtask : rd
   task automatic idle();
      o_sfr.wr = 1'b0;
      o_sfr.rd = 1'b0;
      @(posedge i_clk) #1;
   endtask : idle
   task automatic vec(input int n);
      o_vec[n] = 1'b1;
      @(posedge i_clk) #1;
      o_vec = 4'h0;
   endtask : vec
endmodule : tmc_core_model
`default_nettype wire

/* File: tb/tmc_timers_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module tmc_timers_chk (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire tmc_pkg::tmc_sfr_req_s i_sfr,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_first_overflow_pulse,
   input wire logic o_second_overflow_pulse
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic [1:0] run_sh;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         run_sh <= 2'h0;
      end else if (i_sfr.wr && i_sfr.addr == 8'h88) begin
         run_sh <= {i_sfr.wdata[6], i_sfr.wdata[4]};
      end
   end
   sequence s_wr_rd(a);
      (i_sfr.wr && !i_sfr.rd && i_sfr.addr == a) ##1 (i_sfr.rd && !i_sfr.wr && i_sfr.addr == a);
   endsequence
   property p_mode_back;
      s_wr_rd(8'h89) |=> o_sfr_rdata == $past(i_sfr.wdata, 2);
   endproperty
   property p_rate_back;
      s_wr_rd(8'h8e) |=> o_sfr_rdata == $past(i_sfr.wdata, 2);
   endproperty
   property p_p0_one; o_first_overflow_pulse |=> !o_first_overflow_pulse; endproperty
   property p_p1_one; o_second_overflow_pulse |=> !o_second_overflow_pulse; endproperty
   property p_p0_run; o_first_overflow_pulse |-> $past(run_sh[0]); endproperty
   property p_p1_run; o_second_overflow_pulse |-> $past(run_sh[1]); endproperty
   property p_hold; !i_sfr.rd |=> $stable(o_sfr_rdata); endproperty
   property p_unmap; i_sfr.rd && i_sfr.addr > 8'h8e |=> o_sfr_rdata == 8'h00; endproperty
   a_p0_one: assert property (p_p0_one) else $error("first pulse too long");
   a_p1_one: assert property (p_p1_one) else $error("second pulse too long");
   a_p0_run: assert property (p_p0_run) else $error("first pulse while stopped");
   a_p1_run: assert property (p_p1_run) else $error("second pulse while stopped");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_mode_back: assert property (p_mode_back) else $error("mode readback");
   a_rate_back: assert property (p_rate_back) else $error("rate readback");
endmodule : tmc_timers_chk
bind tmc_timers tmc_timers_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sfr(i_sfr),
   .o_sfr_rdata(o_sfr_rdata), .o_first_overflow_pulse(o_first_overflow_pulse),
   .o_second_overflow_pulse(o_second_overflow_pulse));
`default_nettype wire

/* File: tb/tb_tmc_timers.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_tmc_timers;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   tmc_pkg::tmc_sfr_req_s sfr;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [3:0] vec;
   logic irq0_n = 1'b1, irq1_n = 1'b1, cnt0 = 1'b0, cnt1 = 1'b0;
   logic p0, p1;
   int miscompares = 0;
   int samples_checked = 0;
   int k;
   always #2.5 i_clk = ~i_clk;
   tmc_core_model u_core (.i_clk(i_clk), .i_rdata(rdata), .o_sfr(sfr), .o_vec(vec));
   tmc_timers u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sfr(sfr), .o_sfr_rdata(rdata),
      .i_first_ext_irq_pin_n(irq0_n), .i_second_ext_irq_pin_n(irq1_n),
      .i_first_count_pin(cnt0), .i_second_count_pin(cnt1),
      .i_vector_first_timer(vec[0]), .i_vector_second_timer(vec[1]),
      .i_vector_first_ext_irq(vec[2]), .i_vector_second_ext_irq(vec[3]),
      .o_first_overflow_pulse(p0), .o_second_overflow_pulse(p1));
   task automatic give_verdict();
      if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      u_core.rd(a, d);
      `CHK(d & m, e)
   endtask : rchk
   task automatic wait_pulse(input logic s, input int n);
      for (k = 0; k < n; k++) begin
         @(posedge i_clk) #1;
         if ((s ? p1 : p0) === 1'b1) break;
      end
   endtask : wait_pulse
   task automatic need_pulse(input logic s, input int n);
      wait_pulse(s, n);
      if (k == n) begin
         miscompares++;
         give_verdict();
      end
   endtask : need_pulse
   task automatic fall1();
      cnt1 = 1'b1;
      @(posedge i_clk) #1;
      cnt1 = 1'b0;
   endtask : fall1
   task automatic fall0();
      cnt0 = 1'b1;
      @(posedge i_clk) #1;
      cnt0 = 1'b0;
   endtask : fall0
   initial begin
      repeat (5) @(posedge i_clk);
      #1 i_sys_rst = 1'b0;
      rchk(8'h88, 8'hff, 8'h00);
      rchk(8'h89, 8'hff, 8'h00);
      rchk(8'h8e, 8'hff, 8'h01);
      rchk(8'h90, 8'hff, 8'h00);
      u_core.wr(8'h8e, 8'h08);
      u_core.wr(8'h89, 8'h01);
      u_core.wr(8'h8c, 8'hff);
      u_core.wr(8'h8a, 8'hfd);
      u_core.wr(8'h88, 8'h10);
      u_core.idle();
      need_pulse(1'b0, 40);
      rchk(8'h8a, 8'hff, 8'h00);
      rchk(8'h8c, 8'hff, 8'h00);
      rchk(8'h88, 8'hff, 8'h30);
      u_core.idle();
      u_core.vec(0);
      rchk(8'h88, 8'hff, 8'h10);
      u_core.wr(8'h89, 8'h02);
      rchk(8'h89, 8'hff, 8'h02);
      u_core.wr(8'h8c, 8'hfe);
      u_core.wr(8'h8a, 8'hfe);
      u_core.idle();
      need_pulse(1'b0, 40);
      wait_pulse(1'b0, 60);
      `CHK(k + 1, 8)
      u_core.wr(8'h8e, 8'h00);
      rchk(8'h8e, 8'hff, 8'h00);
      u_core.idle();
      need_pulse(1'b0, 100);
      wait_pulse(1'b0, 60);
      `CHK(k + 1, 24)
      u_core.wr(8'h88, 8'h40);
      u_core.wr(8'h89, 8'hc0);
      u_core.wr(8'h8d, 8'hff);
      u_core.wr(8'h8b, 8'hff);
      u_core.idle();
      irq1_n = 1'b0;
      fall1();
      wait_pulse(1'b1, 10);
      `CHK(k, 10)
      irq1_n = 1'b1;
      fall1();
      need_pulse(1'b1, 10);
      rchk(8'h8d, 8'hff, 8'h00);
      rchk(8'h8b, 8'h1f, 8'h00);
      rchk(8'h8b, 8'he0, 8'he0);
      rchk(8'h88, 8'hff, 8'hc0);
      u_core.wr(8'h88, 8'h00);
      u_core.idle();
      irq0_n = 1'b0;
      u_core.idle();
      rchk(8'h88, 8'hff, 8'h02);
      u_core.wr(8'h88, 8'h00);
      rchk(8'h88, 8'hff, 8'h02);
      u_core.wr(8'h88, 8'h01);
      u_core.wr(8'h88, 8'h01);
      rchk(8'h88, 8'hff, 8'h01);
      u_core.idle();
      irq0_n = 1'b1;
      u_core.idle();
      irq0_n = 1'b0;
      u_core.idle();
      u_core.idle();
      rchk(8'h88, 8'hff, 8'h03);
      u_core.idle();
      u_core.vec(2);
      rchk(8'h88, 8'hff, 8'h01);
      u_core.wr(8'h8e, 8'h08);
      u_core.wr(8'h89, 8'h37);
      u_core.wr(8'h8b, 8'h5a);
      u_core.wr(8'h8a, 8'hff);
      u_core.wr(8'h8c, 8'hfe);
      u_core.wr(8'h88, 8'h51);
      u_core.idle();
      need_pulse(1'b1, 20);
      rchk(8'h8c, 8'hff, 8'h00);
      rchk(8'h8b, 8'hff, 8'h5a);
      rchk(8'h88, 8'hff, 8'hd1);
      u_core.idle();
      fall0();
      need_pulse(1'b0, 10);
      rchk(8'h8a, 8'hff, 8'h00);
      u_core.idle();
      u_core.vec(1);
      rchk(8'h88, 8'hff, 8'h71);
      give_verdict();
   end
endmodule : tb_tmc_timers
`default_nettype wire
